// >>> hdl/lpc_mode_ctrl.sv
// Low-power mode controller: command registers, power state machine, wake logic.
// Assumes wake and bus pins are asynchronous and activity pulses share clk.
`timescale 1ns/100ps
`default_nettype none
module lpc_mode_ctrl
   import lpc_pkg::*;
#(
   parameter int CYC_PER_MS = CYCLES_PER_MS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [DATA_W-1:0] regRdData,
   input wire logic usbMode,
   input wire logic usbSuspend,
   input wire logic triggerInputN,
   input wire logic ctsIn,
   input wire logic aimWakeInputN,
   input wire logic readActivity,
   input wire logic dataOutActivity,
   output logic powerDownIndicator,
   output logic readyToScan
);
   // ==========================================================
   // Digit decoding
   function automatic logic digitsValid(input logic [15:0] d);
      digitsValid = (d[15:12] <= 4'h9) && (d[11:8] <= 4'h9) && (d[7:4] <= 4'h9)
         && (d[3:0] <= 4'h9);
   endfunction : digitsValid
   function automatic logic [DWELL_W-1:0] digitsWeighted(input logic [15:0] d);
      digitsWeighted = DWELL_W'(d[15:12]) * 14'd1000 + DWELL_W'(d[11:8]) * 14'd100
         + DWELL_W'(d[7:4]) * 14'd10 + DWELL_W'(d[3:0]);
   endfunction : digitsWeighted
   // ==========================================================
   // Pin synchronisers
   logic [4:0] pinMeta_reg, pinSync_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta_reg <= 5'h1F;
         pinSync_reg <= 5'h1F;
      end else begin
         pinMeta_reg <= {usbMode, usbSuspend, triggerInputN, ctsIn, aimWakeInputN};
         pinSync_reg <= pinMeta_reg;
      end
   end
   logic usbModeS, suspendS, trigActive, ctsActive, aimActive;
   assign usbModeS = pinSync_reg[4];
   assign suspendS = pinSync_reg[3];
   assign trigActive = !pinSync_reg[2];
   assign ctsActive = !pinSync_reg[1];
   assign aimActive = !pinSync_reg[0];
   // ==========================================================
   // Configuration registers
   logic cmdWrite, cmdDisable, cmdEnable, cmdDelay, digitsOk;
   logic enable_reg, enable_next;
   logic configured_reg, configured_next;
   logic badDigit_reg, badDigit_next;
   logic [15:0] digits_reg, digits_next;
   logic [DWELL_W-1:0] dwell_reg, dwell_next;
   assign cmdWrite = regWrite && (regAddr == REG_CMD_OFFS);
   assign cmdDisable = cmdWrite && (regWrData[1:0] == CMD_LOW_POWER_DISABLE);
   assign cmdEnable = cmdWrite && (regWrData[1:0] == CMD_LOW_POWER_ENABLE);
   assign cmdDelay = cmdWrite && (regWrData[1:0] == CMD_LOW_POWER_DELAY);
   assign digitsOk = digitsValid(digits_reg);
   always_comb begin
      enable_next = enable_reg;
      configured_next = configured_reg;
      badDigit_next = badDigit_reg;
      digits_next = digits_reg;
      dwell_next = dwell_reg;
      if (regWrite && regAddr == REG_DIGITS_OFFS) begin
         digits_next = regWrData[15:0];
      end
      if (cmdDisable) begin
         enable_next = 1'b0; // RULE1
      end
      if (cmdEnable) begin
         enable_next = 1'b1; // RULE1
         if (!configured_reg) begin
            dwell_next = DEFAULT_DWELL_S; // RULE2
         end
      end
      if (cmdDelay) begin
         badDigit_next = !digitsOk;
         if (digitsOk) begin
            dwell_next = digitsWeighted(digits_reg); // RULE3
            configured_next = 1'b1;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_reg <= 1'b0;
         configured_reg <= 1'b0;
         badDigit_reg <= 1'b0;
         digits_reg <= 16'h0000;
         dwell_reg <= DEFAULT_DWELL_S;
      end else begin
         enable_reg <= enable_next;
         configured_reg <= configured_next;
         badDigit_reg <= badDigit_next;
         digits_reg <= digits_next;
         dwell_reg <= dwell_next; // RULE9
      end
   end
   // ==========================================================
   // Power state machine
   lpc_state_t state_reg, state_next;
   logic timerDone, timerRestart, wakeEvent, activity, enterOk;
   logic [MS_W-1:0] targetMs;
   logic powerDown_reg, powerDown_next;
   logic ready_reg, ready_next;
   assign activity = readActivity || dataOutActivity || regWrite;
   assign wakeEvent = usbModeS ? (trigActive || aimActive)
      : (trigActive || ctsActive || aimActive); // RULE11
   assign enterOk = enable_reg && timerDone && (!usbModeS || suspendS); // RULE7
   always_comb begin
      if (state_reg == ST_RECOVER) begin
         targetMs = MS_W'(RECOVERY_MS);
      end else if (dwell_reg == '0) begin
         targetMs = MS_W'(ZERO_DWELL_MS); // RULE4
      end else begin
         targetMs = MS_W'(dwell_reg) * MS_W'(MS_PER_S);
      end
   end
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_STANDBY: begin
            if (enterOk && !activity) begin
               state_next = ST_LOW_POWER; // RULE6
            end
         end
         ST_LOW_POWER: begin
            if (wakeEvent) begin
               state_next = ST_RECOVER; // RULE12
            end
         end
         ST_RECOVER: begin
            if (timerDone) begin
               state_next = ST_STANDBY; // RULE10
            end
         end
         default: begin
            state_next = ST_STANDBY;
         end
      endcase
      timerRestart = (state_next != state_reg)
         || (state_reg == ST_STANDBY && activity); // RULE5 RULE13
      powerDown_next = (state_next == ST_LOW_POWER); // RULE6 RULE12
      ready_next = (state_next == ST_STANDBY); // RULE10
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_STANDBY;
         powerDown_reg <= 1'b0;
         ready_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         powerDown_reg <= powerDown_next;
         ready_reg <= ready_next;
      end
   end
   lpc_ms_timer #(
      .CYC_PER_MS(CYC_PER_MS)
   ) lpc_ms_timer_i (
      .clk(clk),
      .rst_n(rst_n),
      .restart(timerRestart),
      .targetMs(targetMs),
      .done(timerDone)
   );
   assign powerDownIndicator = powerDown_reg;
   assign readyToScan = ready_reg;
   // ==========================================================
   // Read port
   logic [DATA_W-1:0] rdData_reg, rdData_next;
   always_comb begin
      rdData_next = '0;
      if (regRead) begin
         case (regAddr)
            REG_DIGITS_OFFS: begin
               rdData_next = {16'h0000, digits_reg};
            end
            REG_STATUS_OFFS: begin
               rdData_next[STAT_STATE_POS +: 2] = state_reg;
               rdData_next[STAT_ENABLE_POS] = enable_reg;
               rdData_next[STAT_PDOWN_POS] = powerDown_reg;
               rdData_next[STAT_READY_POS] = ready_reg;
               rdData_next[STAT_CONFIGURED_POS] = configured_reg;
               rdData_next[STAT_BADDIGIT_POS] = badDigit_reg;
            end
            REG_DWELL_OFFS: begin
               rdData_next = {18'h00000, dwell_reg};
            end
            default: begin
               rdData_next = '0;
            end
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_reg <= 32'h00000000;
      end else begin
         rdData_reg <= rdData_next;
      end
   end
   assign regRdData = rdData_reg;
   // ==========================================================
   // Assertions
   disable_cmd_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
      cmdDisable |=> !enable_reg)
      else $error("Disable command did not clear enable");
   enable_default_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
      (cmdEnable && !configured_reg) |=> (dwell_reg == DEFAULT_DWELL_S))
      else $error("Enable did not load default dwell");
   delay_weight_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
      (cmdDelay && digitsOk) |=> (dwell_reg == digitsWeighted($past(digits_reg))))
      else $error("Dwell not weighted from digits");
   zero_dwell_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      (state_reg == ST_STANDBY && dwell_reg == '0) |-> (targetMs == MS_W'(150)))
      else $error("Zero dwell not mapped to 150 ms");
   enter_low_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
      (state_reg == ST_STANDBY && state_next == ST_LOW_POWER)
      |-> ##1 powerDownIndicator [*2] or ##1 (powerDownIndicator && wakeEvent))
      else $error("Indicator not raised on low power");
   usb_cond_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
      (usbModeS && state_reg == ST_STANDBY && state_next == ST_LOW_POWER)
      |-> (suspendS && enable_reg && timerDone))
      else $error("USB low power entered without all conditions");
   config_kept_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
      $rose(powerDown_reg) |-> ($stable(dwell_reg) && $stable(enable_reg)))
      else $error("Configuration changed on low power entry");
   wake_path_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
      (state_reg == ST_LOW_POWER && wakeEvent) |=> (state_reg == ST_RECOVER)
      ##1 !powerDownIndicator)
      else $error("Wake did not leave low power");
   idle_restart_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
      (state_reg == ST_STANDBY && activity) |=> (state_reg == ST_STANDBY))
      else $error("Low power entered despite activity");
   ready_standby_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
      (state_reg == ST_STANDBY) |-> readyToScan)
      else $error("Not ready in Standby");
   dwell_range_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
      dwell_reg <= DWELL_MAX_S)
      else $error("Dwell outside the accepted range");
endmodule : lpc_mode_ctrl
`default_nettype wire

// >>> hdl/lpc_ms_timer.sv
// Millisecond timer with restart, used for the dwell and the wake recovery.
// Assumes restart and target come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module lpc_ms_timer
   import lpc_pkg::*;
#(
   parameter int CYC_PER_MS = CYCLES_PER_MS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic [MS_W-1:0] targetMs,
   output logic done
);
   // ==========================================================
   // Elaboration check
   generate
      if (CYC_PER_MS < 1 || CYC_PER_MS > 16777215) begin : g_bad
         $error("CYC_PER_MS out of range");
      end
   endgenerate
   // ==========================================================
   // Prescaler and millisecond counter
   logic [23:0] preCnt_reg, preCnt_next;
   logic [MS_W-1:0] msCnt_reg, msCnt_next;
   logic done_reg, done_next;
   always_comb begin
      preCnt_next = preCnt_reg;
      msCnt_next = msCnt_reg;
      if (restart) begin
         preCnt_next = 24'h000000;
         msCnt_next = '0;
      end else if (msCnt_reg < targetMs) begin
         if (preCnt_reg == 24'(CYC_PER_MS - 1)) begin
            preCnt_next = 24'h000000;
            msCnt_next = msCnt_reg + 1'b1;
         end else begin
            preCnt_next = preCnt_reg + 24'h000001;
         end
      end
      done_next = !restart && (msCnt_next >= targetMs);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         preCnt_reg <= 24'h000000;
         msCnt_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         preCnt_reg <= preCnt_next;
         msCnt_reg <= msCnt_next;
         done_reg <= done_next;
      end
   end
   assign done = done_reg;
endmodule : lpc_ms_timer
`default_nettype wire

// >>> inc/lpc_pkg.sv
// Constants, register map and state codes of the low-power mode controller.
// Assumes one 200 MHz clock and a plain strobe register port on the same clock.
//
// Functional notes
// RULE1 - Disable and enable commands; disabled by default.
// RULE2 - Enabling without configured dwell uses 5 s.
// RULE3 - Delay command weights four digits, 0 to 9999.
// RULE4 - Zero dwell means an effective 150 ms.
// RULE5 - Dwell counts only in idle Standby.
// RULE6 - Dwell elapsed: enter low power, indicator high.
// RULE7 - USB needs enable, dwell elapsed and suspend.
// RULE8 - USB host chooses when to suspend.
// RULE9 - Configuration is kept through low power.
// RULE10 - Ready 37 ms after wake, immediately in Standby.
// RULE11 - UART host wakes with trigger, CTS, aim.
// RULE12 - Wake drops indicator, back to Standby, restart count.
// RULE13 - Read, output or command restarts the dwell count.
`default_nettype none
package lpc_pkg;
   // ==========================================================
   // Register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [3:0] REG_CMD_OFFS = 4'h0;
   localparam logic [3:0] REG_DIGITS_OFFS = 4'h4;
   localparam logic [3:0] REG_STATUS_OFFS = 4'h8;
   localparam logic [3:0] REG_DWELL_OFFS = 4'hC;
   // ==========================================================
   // Command codes written to the command register
   localparam logic [1:0] CMD_LOW_POWER_DISABLE = 2'h0;
   localparam logic [1:0] CMD_LOW_POWER_ENABLE = 2'h1;
   localparam logic [1:0] CMD_LOW_POWER_DELAY = 2'h2;
   // ==========================================================
   // Field positions of the status register
   localparam int STAT_STATE_POS = 0;
   localparam int STAT_ENABLE_POS = 2;
   localparam int STAT_PDOWN_POS = 3;
   localparam int STAT_READY_POS = 4;
   localparam int STAT_CONFIGURED_POS = 5;
   localparam int STAT_BADDIGIT_POS = 6;
   // ==========================================================
   // Reset values and timing
   localparam int DWELL_W = 14;
   localparam int MS_W = 24;
   localparam logic [13:0] DWELL_MAX_S = 14'h270F;
   localparam logic [13:0] DEFAULT_DWELL_S = 14'h0005;
   localparam int ZERO_DWELL_MS = 150;
   localparam int RECOVERY_MS = 37;
   localparam int MS_PER_S = 1000;
   localparam int CLK_FREQ_HZ = 200_000_000;
   localparam int CYCLES_PER_MS = CLK_FREQ_HZ / MS_PER_S;
   // ==========================================================
   // Power states
   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_LOW_POWER = 2'b01,
      ST_RECOVER = 2'b10
   } lpc_state_t;
endpackage : lpc_pkg
`default_nettype wire

// >>> tb/lpc_host_model.sv
// Host model: puts the USB bus in suspend after idle traffic and pulses one wake pin.
// Assumes traffic, suspendEn, wakeReq and wakeSel come from the bench on clk.
`timescale 1ns/100ps
`default_nettype none
module lpc_host_model #(
   parameter int IDLE_CYC = 32,
   parameter int WAKE_CYC = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic traffic,
   input wire logic suspendEn,
   input wire logic wakeReq,
   input wire logic [1:0] wakeSel,
   output logic usbSuspend,
   output logic triggerInputN,
   output logic ctsIn,
   output logic aimWakeInputN
);
   // ==========================================================
   // Idle and wake counters
   int idleCnt;
   int wakeCnt;
   logic [1:0] sel;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idleCnt <= 0;
         wakeCnt <= 0;
         sel <= 2'h0;
      end else begin
         if (traffic || wakeReq) begin
            idleCnt <= 0;
         end else if (idleCnt < IDLE_CYC) begin
            idleCnt <= idleCnt + 1;
         end
         if (wakeReq) begin
            wakeCnt <= WAKE_CYC;
            sel <= wakeSel;
         end else if (wakeCnt != 0) begin
            wakeCnt <= wakeCnt - 1;
         end
      end
   end
   // ==========================================================
   // Pins
   assign usbSuspend = suspendEn && (idleCnt >= IDLE_CYC) && (wakeCnt == 0);
   assign triggerInputN = !((wakeCnt != 0) && (sel == 2'h0));
   assign ctsIn = !((wakeCnt != 0) && (sel == 2'h1));
   assign aimWakeInputN = !((wakeCnt != 0) && (sel == 2'h2));
endmodule : lpc_host_model
`default_nettype wire

// >>> tb/lpc_mode_ctrl_bench.sv
// Self-checking bench of the low-power mode controller with a host model.
// Assumes the controller is built with CYC_PER_MS of 4.
`timescale 1ns/100ps
`default_nettype none
module lpc_mode_ctrl_bench
   import lpc_pkg::*;
();
   logic clk = 1'b0;
   logic rst_n;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWrData;
   logic regWrite;
   logic regRead;
   logic [DATA_W-1:0] regRdData;
   logic usbMode;
   logic readActivity;
   logic dataOutActivity;
   logic pd;
   logic ready;
   logic suspendEn;
   logic wakeReq;
   logic [1:0] wakeSel;
   wire logic usbSuspend;
   wire logic trigger_input_n;
   wire logic cts;
   wire logic aimN;
   wire logic traffic = regWrite | regRead | readActivity | dataOutActivity;
   int errors = 0;
   int checked = 0;
   int n;
   logic [31:0] d;
   logic [31:0] expDw;
   logic [15:0] g;
   always #2.5 clk = ~clk;
   lpc_mode_ctrl #(.CYC_PER_MS(4)) lpc_mode_ctrl_i (.clk(clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .usbMode(usbMode), .usbSuspend(usbSuspend),
      .triggerInputN(trigger_input_n), .ctsIn(cts), .aimWakeInputN(aimN),
      .readActivity(readActivity), .dataOutActivity(dataOutActivity),
      .powerDownIndicator(pd), .readyToScan(ready));
   lpc_host_model lpc_host_model_i (.clk(clk), .rst_n(rst_n), .traffic(traffic),
      .suspendEn(suspendEn), .wakeReq(wakeReq), .wakeSel(wakeSel),
      .usbSuspend(usbSuspend), .triggerInputN(trigger_input_n), .ctsIn(cts), .aimWakeInputN(aimN));
   // ==========================================================
   // Helpers
   function automatic logic [31:0] dwellOf(input logic [15:0] v);
      return 32'(v[15:12]) * 1000 + 32'(v[11:8]) * 100 + 32'(v[7:4]) * 10 + 32'(v[3:0]);
   endfunction : dwellOf
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      regAddr <= a;
      regWrData <= v;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 v = regRdData;
      @(posedge clk);
   endtask : rd
   task automatic waitFor(input logic useRdy, input logic v, output int c);
      c = 0;
      @(negedge clk);
      while (((useRdy ? ready : pd) !== v) && c < 3000) begin
         @(negedge clk);
         c++;
      end
      @(posedge clk);
   endtask : waitFor
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   // ==========================================================
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      complete_run();
   end
   // ==========================================================
   // Tests
   initial begin
      rst_n = 1'b0;
      regAddr = 4'h0;
      regWrData = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
      usbMode = 1'b0;
      readActivity = 1'b0;
      dataOutActivity = 1'b0;
      suspendEn = 1'b0;
      wakeReq = 1'b0;
      wakeSel = 2'h0;
      void'($urandom(31513));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("ready", 32'(ready), 32'h1);
      rd(REG_STATUS_OFFS, d);
      check("status", d, 32'h10);
      wr(REG_CMD_OFFS, 32'(CMD_LOW_POWER_ENABLE));
      rd(REG_DWELL_OFFS, d);
      check("dwell", d, 32'(DEFAULT_DWELL_S));
      rd(REG_STATUS_OFFS, d);
      check("enable", 32'(d[STAT_ENABLE_POS]), 32'h1);
      for (int i = 0; i < 5; i++) begin
         g = {4'($urandom_range(9)), 4'($urandom_range(9)), 4'($urandom_range(9)),
              4'($urandom_range(9))};
         if (i == 0) g = 16'h9999;
         if (i == 4) g = 16'h0000;
         if (i == 3) g[7:4] = 4'hA;
         wr(REG_DIGITS_OFFS, {16'h0000, g});
         wr(REG_CMD_OFFS, 32'(CMD_LOW_POWER_DELAY));
         if (i != 3) expDw = dwellOf(g);
         rd(REG_DWELL_OFFS, d);
         check("dwell", d, expDw);
         rd(REG_DIGITS_OFFS, d);
         check("digits", d, {16'h0000, g});
         rd(REG_STATUS_OFFS, d);
         check("badDigit", 32'(d[STAT_BADDIGIT_POS]), 32'(i == 3));
      end
      wr(REG_CMD_OFFS, 32'h00000003);
      wr(REG_DWELL_OFFS, 32'h0000FFFF);
      rd(REG_DWELL_OFFS, d);
      check("dwellRo", d, expDw);
      rd(REG_STATUS_OFFS, d);
      check("enable", 32'(d[STAT_ENABLE_POS]), 32'h1);
      rd(REG_CMD_OFFS, d);
      check("unmapped", d, 32'h00000000);
      for (int k = 0; k < 3; k++) begin
         if (k < 2) begin
            repeat (200 + $urandom_range(200)) @(posedge clk);
            if (k == 1) dataOutActivity <= 1'b1;
            else readActivity <= 1'b1;
            @(posedge clk);
            readActivity <= 1'b0;
            dataOutActivity <= 1'b0;
         end
         waitFor(1'b0, 1'b1, n);
         check("dwellCyc", (n inside {[595:612]}) ? 32'h1 : 32'(n), 32'h1);
         check("ready", 32'(ready), 32'h0);
         rd(REG_STATUS_OFFS, d);
         check("state", 32'(d[1:0]), 32'h1);
         wr(REG_CMD_OFFS, 32'(CMD_LOW_POWER_ENABLE));
         rd(REG_DWELL_OFFS, d);
         check("dwell", d, expDw);
         check("pdown", 32'(pd), 32'h1);
         wakeSel <= 2'(k);
         wakeReq <= 1'b1;
         @(posedge clk);
         wakeReq <= 1'b0;
         waitFor(1'b0, 1'b0, n);
         check("wakeCyc", (n <= 8) ? 32'h1 : 32'(n), 32'h1);
         check("ready", 32'(ready), 32'h0);
         waitFor(1'b1, 1'b1, n);
         check("recoverCyc", (n inside {[140:156]}) ? 32'h1 : 32'(n), 32'h1);
      end
      usbMode <= 1'b1;
      repeat (700) @(posedge clk);
      check("pdown", 32'(pd), 32'h0);
      suspendEn <= 1'b1;
      waitFor(1'b0, 1'b1, n);
      check("suspendCyc", (n <= 8) ? 32'h1 : 32'(n), 32'h1);
      wakeSel <= 2'h1;
      wakeReq <= 1'b1;
      @(posedge clk);
      wakeReq <= 1'b0;
      repeat (12) @(posedge clk);
      check("ctsUsb", 32'(pd), 32'h1);
      wakeSel <= 2'h2;
      wakeReq <= 1'b1;
      @(posedge clk);
      wakeReq <= 1'b0;
      waitFor(1'b0, 1'b0, n);
      check("wakeCyc", (n <= 8) ? 32'h1 : 32'(n), 32'h1);
      wr(REG_CMD_OFFS, 32'(CMD_LOW_POWER_DISABLE));
      usbMode <= 1'b0;
      repeat (1200) @(posedge clk);
      check("pdown", 32'(pd), 32'h0);
      rd(REG_STATUS_OFFS, d);
      check("enable", 32'(d[STAT_ENABLE_POS]), 32'h0);
      wr(REG_CMD_OFFS, 32'(CMD_LOW_POWER_ENABLE));
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      check("pdRst", 32'(pd), 32'h0);
      check("rdRst", regRdData, 32'h00000000);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(REG_STATUS_OFFS, d);
      check("statusRst", d, 32'h10);
      rd(REG_DWELL_OFFS, d);
      check("dwellRst", d, 32'(DEFAULT_DWELL_S));
      complete_run();
   end
endmodule : lpc_mode_ctrl_bench
`default_nettype wire
